/* File: logic/clcd_host.v */
`timescale 1ns/1ps
`default_nettype none
`include "clcd_map.vh"
// Contract
// - Register select high for data transfers, low for instruction transfers.
// - Read/write high requests a read, low requests a write.
// - Strobe held high during reads; device captures writes on strobe fall.
// - Host drives data bus on writes, releases it as input on reads.
// - Register select, read/write and strobe are always host outputs.
// - Commands and init sequences are built from single low-level transfers.
// - Busy flag shows completion; host may poll it before new operations.
module clcd_host #(
	parameter SETUP_CYC  = `CLCD_SETUP_CYC,
	parameter STROBE_CYC = `CLCD_STROBE_CYC,
	parameter HOLD_CYC   = `CLCD_HOLD_CYC
) (
	input  wire                   clk_i,
	input  wire                   rst_i,
	input  wire                   req_valid_i,
	input  wire                   req_read_i,
	input  wire                   req_data_i,
	input  wire [`CLCD_BUS_W-1:0] req_wdata_i,
	output reg                    req_ready_o,
	output reg                    rsp_valid_o,
	output reg  [`CLCD_BUS_W-1:0] rsp_rdata_o,
	output reg                    rsp_busy_o,
	output reg                    reg_select_line_o,
	output reg                    read_write_line_o,
	output reg                    transfer_strobe_o,
	input  wire [`CLCD_BUS_W-1:0] lcd_data_bus_i,
	output reg  [`CLCD_BUS_W-1:0] lcd_data_bus_o,
	output reg                    lcd_data_bus_oe_o
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_IDLE   = 3'h0;
	localparam ST_SETUP  = 3'h1;
	localparam ST_STROBE = 3'h2;
	localparam ST_HOLD   = 3'h3;
	localparam ST_DONE   = 3'h4;

	reg  [2:0]              state;
	reg  [2:0]              next_state;
	reg  [`CLCD_CNT_W-1:0]  cnt;
	reg  [`CLCD_CNT_W-1:0]  next_cnt;
	wire [`CLCD_BUS_W-1:0]  bus_sync;
	reg  [`CLCD_BUS_W-1:0]  rd_cap;
	wire                    take;
	wire                    strobe_on;
	wire                    strobe_off;
	wire                    finish;

	// ----------------------------------------
	// Data bus input sampling
	// ----------------------------------------
	clcd_sync #(
		.W(`CLCD_BUS_W)
	) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i(lcd_data_bus_i),
		.sync_o (bus_sync)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @* begin
		next_state = state;
		next_cnt   = cnt;
		case (state)
			ST_IDLE: begin
				// Ready is low for a cycle after reset; nothing taken then
				if (req_valid_i && req_ready_o) begin
					next_state = ST_SETUP;
					next_cnt   = SETUP_CYC[`CLCD_CNT_W-1:0];
				end
			end
			ST_SETUP: begin
				if (cnt <= `CLCD_CNT_ONE) begin
					next_state = ST_STROBE;
					next_cnt   = STROBE_CYC[`CLCD_CNT_W-1:0];
				end else begin
					next_cnt = cnt - `CLCD_CNT_ONE;
				end
			end
			ST_STROBE: begin
				if (cnt <= `CLCD_CNT_ONE) begin
					next_state = ST_HOLD;
					next_cnt   = HOLD_CYC[`CLCD_CNT_W-1:0];
				end else begin
					next_cnt = cnt - `CLCD_CNT_ONE;
				end
			end
			ST_HOLD: begin
				if (cnt <= `CLCD_CNT_ONE) begin
					next_state = ST_DONE;
				end else begin
					next_cnt = cnt - `CLCD_CNT_ONE;
				end
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
				next_cnt   = `CLCD_CNT_ZERO;
			end
		endcase
	end

	// ----------------------------------------
	// Step strobes
	// ----------------------------------------
	assign take       = (state == ST_IDLE) && req_valid_i && req_ready_o;
	assign strobe_on  = (state == ST_SETUP) && (cnt <= `CLCD_CNT_ONE);
	assign strobe_off = (state == ST_STROBE) && (cnt <= `CLCD_CNT_ONE);
	assign finish     = (state == ST_HOLD) && (cnt <= `CLCD_CNT_ONE);

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			cnt   <= `CLCD_CNT_ZERO;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	// ----------------------------------------
	// Request and response handshake
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			req_ready_o <= 1'h0;
			rsp_valid_o <= 1'h0;
		end else begin
			req_ready_o <= (next_state == ST_IDLE);
			rsp_valid_o <= finish;
		end
	end

	// ----------------------------------------
	// Control pins
	// ----------------------------------------
	// Always driven, also between transfers
	always @(posedge clk_i) begin
		if (rst_i) begin
			reg_select_line_o <= `CLCD_RS_INSTR;
			read_write_line_o <= `CLCD_RW_READ;
			transfer_strobe_o <= 1'h0;
		end else begin
			if (take) begin
				reg_select_line_o <= req_data_i ? `CLCD_RS_DATA : `CLCD_RS_INSTR;
				read_write_line_o <= req_read_i ? `CLCD_RW_READ : `CLCD_RW_WRITE;
			end else if (finish) begin
				// Park at read so an idle bus is never driven by both sides
				read_write_line_o <= `CLCD_RW_READ;
			end
			if (strobe_on) begin
				transfer_strobe_o <= 1'h1;
			end else if (strobe_off) begin
				transfer_strobe_o <= 1'h0;
			end
		end
	end

	// ----------------------------------------
	// Data bus drive
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			lcd_data_bus_o    <= `CLCD_ZERO_BYTE;
			lcd_data_bus_oe_o <= 1'h0;
		end else begin
			if (take) begin
				lcd_data_bus_o    <= req_wdata_i;
				lcd_data_bus_oe_o <= ~req_read_i;
			end else if (finish) begin
				// Released with the return to read, after the write hold
				lcd_data_bus_oe_o <= 1'h0;
			end
		end
	end

	// ----------------------------------------
	// Read capture
	// ----------------------------------------
	// The device may drop the bus as soon as the strobe falls, so the
	// byte is taken on the falling step. STROBE_CYC must exceed the
	// four-cycle sampler latency or a stale byte is returned.
	always @(posedge clk_i) begin
		if (rst_i) begin
			rd_cap <= `CLCD_ZERO_BYTE;
		end else if (strobe_off) begin
			rd_cap <= bus_sync;
		end
	end

	// ----------------------------------------
	// Response
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			rsp_rdata_o <= `CLCD_ZERO_BYTE;
			rsp_busy_o  <= 1'h0;
		end else if (finish) begin
			// Direction is still that of the transfer on this step
			rsp_rdata_o <= read_write_line_o ? rd_cap : `CLCD_ZERO_BYTE;
			rsp_busy_o  <= read_write_line_o & ~reg_select_line_o & rd_cap[`CLCD_BUSY_BIT];
		end
	end
endmodule
`default_nettype wire

/* File: logic/clcd_map.vh */
`ifndef CLCD_MAP_VH
`define CLCD_MAP_VH
// Pin levels
`define CLCD_RS_INSTR      1'h0
`define CLCD_RS_DATA       1'h1
`define CLCD_RW_WRITE      1'h0
`define CLCD_RW_READ       1'h1
// Timing, ns
`define CLCD_CLK_NS        10
`define CLCD_SETUP_NS      60
`define CLCD_STROBE_NS     450
`define CLCD_HOLD_NS       20
`define CLCD_SETUP_CYC     ((`CLCD_SETUP_NS + `CLCD_CLK_NS - 1) / `CLCD_CLK_NS)
`define CLCD_STROBE_CYC    ((`CLCD_STROBE_NS + `CLCD_CLK_NS - 1) / `CLCD_CLK_NS)
`define CLCD_HOLD_CYC      ((`CLCD_HOLD_NS + `CLCD_CLK_NS - 1) / `CLCD_CLK_NS)
// Status byte
`define CLCD_BUSY_BIT      7
`define CLCD_BUS_W         8
`define CLCD_CNT_W         8
`define CLCD_CNT_ONE       8'h01
`define CLCD_CNT_ZERO      8'h00
`define CLCD_ZERO_BYTE     8'h00
`endif

/* File: logic/clcd_sync.v */
`timescale 1ns/1ps
`default_nettype none
// Three-stage sampler; change accepted once stages two and three agree
module clcd_sync #(
	parameter W = 8
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] async_i,
	output reg  [W-1:0] sync_o
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : bit_g
			always @(posedge clk_i) begin
				if (rst_i) begin
					s1[g]     <= 1'h0;
					s2[g]     <= 1'h0;
					s3[g]     <= 1'h0;
					sync_o[g] <= 1'h0;
				end else begin
					s1[g] <= async_i[g];
					s2[g] <= s1[g];
					s3[g] <= s2[g];
					if (s2[g] == s3[g])
						sync_o[g] <= s3[g];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* File: tb/clcd_host_props.sv */
`timescale 1ns/1ps
`default_nettype none
module clcd_host_chk #(parameter STROBE_CYC = 45) (
	input wire logic       clk_i, rst_i, req_valid_i, req_read_i, req_data_i, req_ready_o,
	input wire logic       rsp_valid_o, rsp_busy_o, reg_select_line_o, read_write_line_o,
	input wire logic       transfer_strobe_o, lcd_data_bus_oe_o,
	input wire logic [7:0] rsp_rdata_o, lcd_data_bus_o
);
	localparam int STROBE_PRE = STROBE_CYC + 1;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_rs_kind: assert property (req_valid_i && req_ready_o |=> reg_select_line_o == $past(req_data_i))
		else $error("select level");
	chk_rw_kind: assert property (req_valid_i && req_ready_o |=> read_write_line_o == $past(req_read_i))
		else $error("direction level");
	chk_strobe_len: assert property ($fell(transfer_strobe_o) |-> $past(transfer_strobe_o, STROBE_CYC) && !$past(transfer_strobe_o, STROBE_PRE))
		else $error("strobe width");
	chk_bus_write: assert property (transfer_strobe_o && !read_write_line_o |-> lcd_data_bus_oe_o && $stable(lcd_data_bus_o))
		else $error("write bus");
	chk_start_strobe: assert property (req_valid_i && req_ready_o |-> ##[1:8] transfer_strobe_o)
		else $error("no strobe");
	chk_no_clash: assert property (read_write_line_o |-> !lcd_data_bus_oe_o)
		else $error("bus clash");
	chk_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o && req_ready_o)
		else $error("response pulse");
	chk_busy_bit: assert property (rsp_valid_o && rsp_busy_o |-> rsp_rdata_o[7])
		else $error("busy bit");
endmodule
bind clcd_host clcd_host_chk #(.STROBE_CYC(STROBE_CYC)) i_chk (.*);
`default_nettype wire

/* File: tb/clcd_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module clcd_dev_model (
	input wire logic        rs_i, rw_i, en_i,
	input wire logic  [7:0] bus_i,
	output var logic        drv_o,
	output var logic  [7:0] dat_o
);
	logic [7:0] ram [0:127];
	logic [6:0] a = 7'h00;
	logic       busy = 1'h0;
	initial dat_o = 8'h00;
	// Drives only inside a read strobe, so a late host sample sees a wrong byte
	assign drv_o = rw_i & en_i;
	always @(posedge en_i) if (rw_i) dat_o = rs_i ? ram[a] : {busy, a};
	always @(negedge en_i) begin
		if (rs_i) begin
			if (!rw_i) ram[a] = bus_i;
			a = (a == 7'h27) ? 7'h40 : (a == 7'h67) ? 7'h00 : a + 7'h01;
		end else if (!rw_i) begin
			if (bus_i[7]) a = bus_i[6:0];
			busy = 1'h1;
			busy <= #100 1'h0;
		end
	end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       clk_i, rst_i, req_valid_i, req_read_i, req_data_i, req_ready_o, rsp_valid_o, rsp_busy_o;
	logic       rs, rw, en, oe, drv;
	logic [7:0] req_wdata_i, rsp_rdata_o, bus_o, ddat, d [0:3];
	logic [8:0] q [$];
	int         n_mismatch = 0, check_count = 0;
	// Released bus shows the inverse of the device's last read byte
	wire  [7:0] bus = oe ? bus_o : drv ? ddat : ~ddat;
	clcd_host #(.SETUP_CYC(1), .STROBE_CYC(6), .HOLD_CYC(1)) i_dut (.clk_i, .rst_i, .req_valid_i, .req_read_i,
		.req_data_i, .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .rsp_busy_o,
		.reg_select_line_o(rs), .read_write_line_o(rw), .transfer_strobe_o(en),
		.lcd_data_bus_i(bus), .lcd_data_bus_o(bus_o), .lcd_data_bus_oe_o(oe));
	clcd_dev_model i_dev (.rs_i(rs), .rw_i(rw), .en_i(en), .bus_i(bus), .drv_o(drv), .dat_o(ddat));
	initial begin clk_i = 0; forever #5 clk_i = ~clk_i; end
	task print_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task xf(input logic r, s, input logic [7:0] w, e, input logic b);
		@(negedge clk_i);
		{req_valid_i, req_read_i, req_data_i, req_wdata_i} = {1'h1, r, s, w};
		q.push_back({b, e});
		do @(posedge clk_i); while (req_ready_o !== 1'h1);
		@(negedge clk_i) req_valid_i = 0;
	endtask
	always @(negedge clk_i) if (rsp_valid_o === 1'h1) begin
		check_count++;
		if (q.size() == 0 || {rsp_busy_o, rsp_rdata_o} !== q[0]) begin
			n_mismatch++;
			$display("mismatch %0t got %h", $time, {rsp_busy_o, rsp_rdata_o});
		end
		if (q.size() != 0) void'(q.pop_front());
	end
	// ----
	// Sequence
	// ----
	initial begin
		{rst_i, req_valid_i, req_read_i, req_data_i, req_wdata_i} = {4'hB, 8'h00};
		void'($urandom(48));
		repeat (3) @(posedge clk_i);
		@(negedge clk_i) rst_i = 0;
		xf(0, 0, 8'hC0, 8'h00, 0);
		xf(1, 0, 8'h00, 8'hC0, 1);
		xf(1, 0, 8'h00, 8'h40, 0);
		for (int i = 0; i < 4; i++) begin d[i] = $urandom; xf(0, 1, d[i], 8'h00, 0); end
		xf(0, 0, 8'hC0, 8'h00, 0);
		for (int i = 0; i < 4; i++) xf(1, 1, 8'h00, d[i], 0);
		xf(1, 0, 8'h00, 8'h44, 0);
		xf(0, 0, 8'hA7, 8'h00, 0);
		xf(0, 1, 8'h5A, 8'h00, 0);
		xf(1, 0, 8'h00, 8'h40, 0);
		repeat (20) @(posedge clk_i);
		if (q.size() != 0) begin
			n_mismatch++;
			$display("mismatch %0t missing responses", $time);
		end
		print_verdict;
	end
	initial begin #20000; n_mismatch++; print_verdict; end
endmodule
`default_nettype wire
